// ==== rtl/cmb_params.svh ====
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH

// identifier geometry
`define CMB_ID_W 29
`define CMB_STD_LSB 18

// register area select: top address bit
`define CMB_AREA_BUF 1'h0
`define CMB_AREA_GLB 1'h1

// per-buffer word select (low three address bits)
`define CMB_SEL_ID 3'h0
`define CMB_SEL_CFG 3'h1
`define CMB_SEL_CTL 3'h2
`define CMB_SEL_LEN 3'h3
`define CMB_SEL_DLO 3'h4
`define CMB_SEL_DHI 3'h5

// global word select (low three address bits)
`define CMB_G_MASK1 3'h0
`define CMB_G_MASK2 3'h1
`define CMB_G_MASK3 3'h2
`define CMB_G_MASK4 3'h3
`define CMB_G_IRQEN 3'h4
`define CMB_G_IRQST 3'h5
`define CMB_G_HIST 3'h6
`define CMB_G_HCTL 3'h7

// buffer_config_reg fields
`define CMB_CFG_TYPE 2:0
`define CMB_CFG_USE 3
`define CMB_CFG_OWS 4
`define CMB_CFG_RTR 5
`define CMB_CFG_EXT 6

// buffer_control_reg fields
`define CMB_CTL_RDY 0
`define CMB_CTL_TRQ 1
`define CMB_CTL_DN 2
`define CMB_CTL_IE 3

// buffer_length_reg, irq regs, history read word
`define CMB_LEN_DLC 3:0
`define CMB_IRQ_BIT 0
`define CMB_HIST_NUM 7:0
`define CMB_HIST_EMPTY 8
`define CMB_HIST_OVF 9
`define CMB_HCTL_OVF_CLR 0

// reset values
`define CMB_MASK_RST 29'h0000000
`define CMB_RD_RST 32'h0000_0000

`endif

// ==== rtl/cmb_pkg.sv ====
`include "cmb_params.svh"

package cmb_pkg;

   typedef enum logic [2:0] {
      CMB_TX = 3'b000,
      CMB_RX_NOMASK = 3'b001,
      CMB_RX_MASK1 = 3'b010,
      CMB_RX_MASK2 = 3'b011,
      CMB_RX_MASK3 = 3'b100,
      CMB_RX_MASK4 = 3'b101
   } cmb_type_e;

   typedef logic [`CMB_ID_W-1:0] cmb_id_t;

   // gated xor: a set mask bit drops that bit from the compare
   function automatic logic cmb_id_match(input cmb_id_t rx, input cmb_id_t bid, input cmb_id_t mask,
                                         input logic is_ext);
      cmb_id_t diff;
      diff = (rx ^ bid) & ~mask;
      if (!is_ext) begin
         diff[`CMB_STD_LSB-1:0] = '0;
      end
      return (diff == '0);
   endfunction : cmb_id_match

endpackage : cmb_pkg

// ==== rtl/cmb_accept.sv ====
module cmb_accept
   import cmb_pkg::*;
#(
   parameter int BUF_NUM = 32
) (
   input wire logic [BUF_NUM-1:0][`CMB_ID_W-1:0] i_buf_id,
   input wire logic [BUF_NUM-1:0][2:0] i_buf_type,
   input wire logic [BUF_NUM-1:0] i_in_use,
   input wire logic [BUF_NUM-1:0] i_ows,
   input wire logic [BUF_NUM-1:0] i_rtr,
   input wire logic [BUF_NUM-1:0] i_ext,
   input wire logic [BUF_NUM-1:0] i_rdy,
   input wire logic [BUF_NUM-1:0] i_trq,
   input wire logic [BUF_NUM-1:0] i_dn,
   input wire logic [3:0][`CMB_ID_W-1:0] i_mask,
   input wire logic [`CMB_ID_W-1:0] i_frm_id,
   input wire logic i_frm_ext,
   output logic [4:0][BUF_NUM-1:0] o_class_hit,
   output logic [BUF_NUM-1:0] o_free,
   output logic [BUF_NUM-1:0] o_rem_hit
);

   always_comb begin
      o_class_hit = '0;
      o_free = '0;
      o_rem_hit = '0;
      for (int i = 0; i < BUF_NUM; i++) begin
         // same test as any single receive buffer; blocks need no enable
         o_free[i] = !i_dn[i] || i_ows[i];
         case (cmb_type_e'(i_buf_type[i]))
            CMB_TX: begin
               // remote frames ignore overwrite control and the flag
               o_rem_hit[i] = i_in_use[i] && i_rdy[i] && !i_rtr[i] && !i_trq[i] && (i_ext[i] == i_frm_ext)
                  && cmb_id_match(i_frm_id, i_buf_id[i], `CMB_MASK_RST, i_frm_ext);
            end
            CMB_RX_NOMASK: begin
               o_class_hit[0][i] = i_in_use[i] && i_rdy[i] && (i_ext[i] == i_frm_ext)
                  && cmb_id_match(i_frm_id, i_buf_id[i], `CMB_MASK_RST, i_frm_ext);
            end
            CMB_RX_MASK1, CMB_RX_MASK2, CMB_RX_MASK3, CMB_RX_MASK4: begin
               // match after masking, so buffers differing in masked bits pool together
               o_class_hit[i_buf_type[i] - 3'h1][i] = i_in_use[i] && i_rdy[i] && (i_ext[i] == i_frm_ext)
                  && cmb_id_match(i_frm_id, i_buf_id[i], i_mask[i_buf_type[i] - 3'h2], i_frm_ext);
            end
            default: begin
            end
         endcase
      end
   end

endmodule : cmb_accept

// ==== rtl/cmb_pick.sv ====
module cmb_pick
   import cmb_pkg::*;
#(
   parameter int BUF_NUM = 32,
   localparam int IDX_W = $clog2(BUF_NUM)
) (
   input wire logic [4:0][BUF_NUM-1:0] i_class_hit,
   input wire logic [BUF_NUM-1:0] i_free,
   input wire logic [BUF_NUM-1:0] i_rem_hit,
   input wire logic i_is_remote,
   output logic o_found,
   output logic [IDX_W-1:0] o_idx
);

   function automatic logic [IDX_W-1:0] lowest(input logic [BUF_NUM-1:0] v);
      lowest = '0;
      for (int i = BUF_NUM - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = IDX_W'(i);
         end
      end
   endfunction : lowest

   logic [BUF_NUM-1:0] cand;
   logic done;

   always_comb begin
      cand = '0;
      done = 1'b0;
      if (i_is_remote) begin
         cand = i_rem_hit;
      end else begin
         // first class with any id hit owns the frame, even if all its buffers are full
         for (int c = 0; c < 5; c++) begin
            if (!done && (|i_class_hit[c])) begin
               cand = i_class_hit[c] & i_free;
               done = 1'b1;
            end
         end
      end
      // lowest free member wins, lowest matching transmit buffer for remote; a full block never wraps back to the start
      o_found = |cand;
      o_idx = lowest(cand);
   end

endmodule : cmb_pick

// ==== rtl/cmb_rx_store.sv ====
// What this block does
// - mask bit one drops bit from compare
// - type 010 is receive linked mask one
// - equal type and id form block, ascending
// - store sets new data, blocks overwrite
// - block interrupt only where buffer enable set
// - block buffers use single buffer store test
// - other-type vacancy ignored, frame discarded
// - full block never wraps to lowest
// - block membership compares ids after masking
// - remote goes to idle ready transmit buffer
// - remote writes length, keeps data bytes
// - remote sets new data, logs buffer
// - remote sets done status only where buffer enable set, irq if global enable also set
// - remote ignores overwrite and new data
// - remote takes lowest matching transmit buffer
// - data needs clear flag or overwrite
// - unmasked first, then masks one to four
module cmb_rx_store
   import cmb_pkg::*;
#(
   parameter int BUF_NUM = 32,
   parameter int HIST_DEPTH = 23,
   localparam int IDX_W = $clog2(BUF_NUM),
   localparam int ADDR_W = IDX_W + 4
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rd_data,
   input wire logic i_frm_valid,
   input wire logic [`CMB_ID_W-1:0] i_frm_id,
   input wire logic i_frm_ext,
   input wire logic i_frm_rtr,
   input wire logic [3:0] i_frm_dlc,
   input wire logic [63:0] i_frm_data,
   output logic o_receive_done_irq,
   output logic o_store_valid,
   output logic [IDX_W-1:0] o_store_idx
);

   localparam int PTR_W = $clog2(HIST_DEPTH);

   typedef struct packed {
      logic [BUF_NUM-1:0][`CMB_ID_W-1:0] id;
      logic [BUF_NUM-1:0][2:0] mtype;
      logic [BUF_NUM-1:0] in_use;
      logic [BUF_NUM-1:0] overwrite_select;
      logic [BUF_NUM-1:0] rtr;
      logic [BUF_NUM-1:0] ext;
      logic [BUF_NUM-1:0] rdy;
      logic [BUF_NUM-1:0] transmit_request_flag;
      logic [BUF_NUM-1:0] dn;
      logic [BUF_NUM-1:0] ie;
      logic [BUF_NUM-1:0][3:0] dlc;
      logic [BUF_NUM-1:0][63:0] data;
      logic [3:0][`CMB_ID_W-1:0] mask;
      logic rx_ie;
      logic rx_st;
      logic [HIST_DEPTH-1:0][IDX_W-1:0] hist;
      logic [PTR_W-1:0] wp;
      logic [PTR_W-1:0] rp;
      logic ovf;
      logic [31:0] rd_data;
      logic irq;
      logic sv;
      logic [IDX_W-1:0] sidx;
   } cmb_state_s;

   cmb_state_s st;
   cmb_state_s next_st;

   logic [4:0][BUF_NUM-1:0] class_hit;
   logic [BUF_NUM-1:0] free;
   logic [BUF_NUM-1:0] rem_hit;
   logic found;
   logic [IDX_W-1:0] pick_idx;

   cmb_accept #(
      .BUF_NUM(BUF_NUM)
   ) u_accept (
      .i_buf_id(st.id),
      .i_buf_type(st.mtype),
      .i_in_use(st.in_use),
      .i_ows(st.overwrite_select),
      .i_rtr(st.rtr),
      .i_ext(st.ext),
      .i_rdy(st.rdy),
      .i_trq(st.transmit_request_flag),
      .i_dn(st.dn),
      .i_mask(st.mask),
      .i_frm_id(i_frm_id),
      .i_frm_ext(i_frm_ext),
      .o_class_hit(class_hit),
      .o_free(free),
      .o_rem_hit(rem_hit)
   );

   cmb_pick #(
      .BUF_NUM(BUF_NUM)
   ) u_pick (
      .i_class_hit(class_hit),
      .i_free(free),
      .i_rem_hit(rem_hit),
      .i_is_remote(i_frm_rtr),
      .o_found(found),
      .o_idx(pick_idx)
   );

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(HIST_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
      ptr_dec = (p == '0) ? PTR_W'(HIST_DEPTH - 1) : p - 1'b1;
   endfunction : ptr_dec

   logic area;
   logic [IDX_W-1:0] widx;
   logic [2:0] sel;
   logic hist_empty;
   logic hist_full;
   logic pop;

   assign area = i_addr[ADDR_W-1];
   assign widx = i_addr[IDX_W+2:3];
   assign sel = i_addr[2:0];
   assign hist_empty = (st.rp == st.wp);
   assign hist_full = (ptr_inc(st.wp) == st.rp);
   assign pop = i_rd && (area == `CMB_AREA_GLB) && (sel == `CMB_G_HIST) && !hist_empty;

   always_comb begin
      next_st = st;
      next_st.irq = 1'b0;
      next_st.sv = 1'b0;
      next_st.rd_data = `CMB_RD_RST;

      // read path: data stands only in the cycle after the strobe
      if (i_rd) begin
         if (area == `CMB_AREA_BUF) begin
            case (sel)
               `CMB_SEL_ID: next_st.rd_data = {3'h0, st.id[widx]};
               `CMB_SEL_CFG: begin
                  next_st.rd_data[`CMB_CFG_TYPE] = st.mtype[widx];
                  next_st.rd_data[`CMB_CFG_USE] = st.in_use[widx];
                  next_st.rd_data[`CMB_CFG_OWS] = st.overwrite_select[widx];
                  next_st.rd_data[`CMB_CFG_RTR] = st.rtr[widx];
                  next_st.rd_data[`CMB_CFG_EXT] = st.ext[widx];
               end
               `CMB_SEL_CTL: begin
                  next_st.rd_data[`CMB_CTL_RDY] = st.rdy[widx];
                  next_st.rd_data[`CMB_CTL_TRQ] = st.transmit_request_flag[widx];
                  next_st.rd_data[`CMB_CTL_DN] = st.dn[widx];
                  next_st.rd_data[`CMB_CTL_IE] = st.ie[widx];
               end
               `CMB_SEL_LEN: next_st.rd_data[`CMB_LEN_DLC] = st.dlc[widx];
               `CMB_SEL_DLO: next_st.rd_data = st.data[widx][31:0];
               `CMB_SEL_DHI: next_st.rd_data = st.data[widx][63:32];
               default: next_st.rd_data = `CMB_RD_RST;
            endcase
         end else begin
            case (sel)
               `CMB_G_MASK1, `CMB_G_MASK2, `CMB_G_MASK3, `CMB_G_MASK4: begin
                  next_st.rd_data = {3'h0, st.mask[sel[1:0]]};
               end
               `CMB_G_IRQEN: next_st.rd_data[`CMB_IRQ_BIT] = st.rx_ie;
               `CMB_G_IRQST: next_st.rd_data[`CMB_IRQ_BIT] = st.rx_st;
               `CMB_G_HIST: begin
                  next_st.rd_data[`CMB_HIST_NUM] = 8'(st.hist[st.rp]);
                  next_st.rd_data[`CMB_HIST_EMPTY] = hist_empty;
                  next_st.rd_data[`CMB_HIST_OVF] = st.ovf;
               end
               default: next_st.rd_data = `CMB_RD_RST;
            endcase
         end
      end
      if (pop) begin
         next_st.rp = ptr_inc(st.rp);
      end

      // software writes come first so a same-cycle store wins
      if (i_wr) begin
         if (area == `CMB_AREA_BUF) begin
            case (sel)
               `CMB_SEL_ID: next_st.id[widx] = i_wr_data[`CMB_ID_W-1:0];
               `CMB_SEL_CFG: begin
                  next_st.mtype[widx] = i_wr_data[`CMB_CFG_TYPE];
                  next_st.in_use[widx] = i_wr_data[`CMB_CFG_USE];
                  next_st.overwrite_select[widx] = i_wr_data[`CMB_CFG_OWS];
                  next_st.rtr[widx] = i_wr_data[`CMB_CFG_RTR];
                  next_st.ext[widx] = i_wr_data[`CMB_CFG_EXT];
               end
               `CMB_SEL_CTL: begin
                  next_st.rdy[widx] = i_wr_data[`CMB_CTL_RDY];
                  next_st.transmit_request_flag[widx] = i_wr_data[`CMB_CTL_TRQ];
                  next_st.dn[widx] = i_wr_data[`CMB_CTL_DN];
                  next_st.ie[widx] = i_wr_data[`CMB_CTL_IE];
               end
               `CMB_SEL_LEN: next_st.dlc[widx] = i_wr_data[`CMB_LEN_DLC];
               `CMB_SEL_DLO: next_st.data[widx][31:0] = i_wr_data;
               `CMB_SEL_DHI: next_st.data[widx][63:32] = i_wr_data;
               default: begin
               end
            endcase
         end else begin
            case (sel)
               `CMB_G_MASK1, `CMB_G_MASK2, `CMB_G_MASK3, `CMB_G_MASK4: begin
                  next_st.mask[sel[1:0]] = i_wr_data[`CMB_ID_W-1:0];
               end
               `CMB_G_IRQEN: next_st.rx_ie = i_wr_data[`CMB_IRQ_BIT];
               `CMB_G_IRQST: begin
                  if (i_wr_data[`CMB_IRQ_BIT]) begin
                     next_st.rx_st = 1'b0;
                  end
               end
               `CMB_G_HCTL: begin
                  if (i_wr_data[`CMB_HCTL_OVF_CLR]) begin
                     next_st.ovf = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // frame store; a frame with no destination is simply dropped
      if (i_frm_valid && found) begin
         next_st.dlc[pick_idx] = i_frm_dlc;
         if (!i_frm_rtr) begin
            next_st.data[pick_idx] = i_frm_data;
            next_st.id[pick_idx] = i_frm_id;
         end
         next_st.dn[pick_idx] = 1'b1;
         // history: when full the newest entry is overwritten and ovf is set, older entries keep their order
         if (hist_full && !pop) begin
            next_st.hist[ptr_dec(st.wp)] = pick_idx;
            next_st.ovf = 1'b1;
         end else begin
            next_st.hist[st.wp] = pick_idx;
            next_st.wp = ptr_inc(st.wp);
         end
         if (st.ie[pick_idx]) begin
            next_st.rx_st = 1'b1;
            next_st.irq = st.rx_ie;
         end
         next_st.sv = 1'b1;
         next_st.sidx = pick_idx;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rd_data = st.rd_data;
   assign o_receive_done_irq = st.irq;
   assign o_store_valid = st.sv;
   assign o_store_idx = st.sidx;

endmodule : cmb_rx_store

// ==== testbench/cmb_rx_store_assertions.sv ====
`include "cmb_params.svh"
module cmb_rx_chk #(
   parameter int BUF_NUM = 32,
   localparam int IDX_W = $clog2(BUF_NUM),
   localparam int ADDR_W = IDX_W + 4
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_frm_valid,
   input wire logic i_frm_ext,
   input wire logic i_frm_rtr,
   input wire logic o_receive_done_irq,
   input wire logic o_store_valid,
   input wire logic [IDX_W-1:0] o_store_idx
);
   timeunit 1ns;
   timeprecision 1ps;
   // software-owned fields only; delayed copy matches the pre-write view of a frame
   logic [BUF_NUM-1:0][6:0] cfg_sh, cfg_q;
   logic [BUF_NUM-1:0] ie_sh, ie_q;
   logic gie_sh, gie_q;
   always_ff @(posedge i_ref_clk) begin
      cfg_q <= cfg_sh;
      ie_q <= ie_sh;
      gie_q <= gie_sh;
      if (!i_rst_b) begin
         cfg_sh <= '0;
         ie_sh <= '0;
         gie_sh <= 1'b0;
      end else if (i_wr && !i_addr[ADDR_W-1]) begin
         if (i_addr[2:0] == `CMB_SEL_CFG) cfg_sh[i_addr[ADDR_W-2:3]] <= i_wr_data[6:0];
         if (i_addr[2:0] == `CMB_SEL_CTL) ie_sh[i_addr[ADDR_W-2:3]] <= i_wr_data[`CMB_CTL_IE];
      end else if (i_wr && i_addr[2:0] == `CMB_G_IRQEN) begin
         gie_sh <= i_wr_data[0];
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   property p_store_cause;
      o_store_valid |-> $past(i_frm_valid);
   endproperty
   a_store_cause: assert property (p_store_cause) else $error("store without frame");
   property p_in_use;
      o_store_valid |-> cfg_q[o_store_idx][3];
   endproperty
   a_in_use: assert property (p_in_use) else $error("store into unused buffer");
   property p_remote_tx;
      o_store_valid && $past(i_frm_rtr) |-> cfg_q[o_store_idx][2:0] == 3'h0 && !cfg_q[o_store_idx][5];
   endproperty
   a_remote_tx: assert property (p_remote_tx) else $error("remote into wrong buffer");
   property p_data_rx;
      o_store_valid && !$past(i_frm_rtr) |-> cfg_q[o_store_idx][2:0] != 3'h0;
   endproperty
   a_data_rx: assert property (p_data_rx) else $error("data into transmit buffer");
   property p_ext;
      o_store_valid |-> cfg_q[o_store_idx][6] == $past(i_frm_ext);
   endproperty
   a_ext: assert property (p_ext) else $error("format mismatch on store");
   property p_irq_gate;
      o_receive_done_irq |-> o_store_valid && ie_q[o_store_idx] && gie_q;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
   property p_irq_due;
      o_store_valid && ie_q[o_store_idx] && gie_q |-> o_receive_done_irq;
   endproperty
   a_irq_due: assert property (p_irq_due) else $error("irq missing");
   property p_no_reuse;
      o_store_valid && $past(o_store_valid) && !$past(i_frm_rtr) && !cfg_q[o_store_idx][4]
         |-> o_store_idx != $past(o_store_idx);
   endproperty
   a_no_reuse: assert property (p_no_reuse) else $error("full buffer overwritten");
endmodule : cmb_rx_chk

// ==== testbench/cmb_frame_src.sv ====
module cmb_frame_src (
   input wire logic i_ref_clk,
   output logic o_frm_valid,
   output logic [28:0] o_frm_id,
   output logic o_frm_ext,
   output logic o_frm_rtr,
   output logic [3:0] o_frm_dlc,
   output logic [63:0] o_frm_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_frm_valid = 1'b0;
      {o_frm_id, o_frm_ext, o_frm_rtr, o_frm_dlc, o_frm_data} = '0;
   end
   // last=0 keeps valid up so the next frame follows with no gap
   task automatic send(input logic [28:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d,
                       input logic last, input logic ext = 1'b0);
      @(posedge i_ref_clk);
      o_frm_valid <= 1'b1;
      o_frm_id <= id;
      o_frm_ext <= ext;
      o_frm_rtr <= rtr;
      o_frm_dlc <= dlc;
      o_frm_data <= d;
      if (last) begin
         @(posedge i_ref_clk);
         o_frm_valid <= 1'b0;
         {o_frm_id, o_frm_ext, o_frm_rtr, o_frm_dlc, o_frm_data} <= ~{id, ext, rtr, dlc, d};
      end
   endtask : send
endmodule : cmb_frame_src

// ==== testbench/tb_cmb_rx_store.sv ====
module tb_cmb_rx_store;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [28:0] ID_A = 29'h1000_0000;
   localparam logic [28:0] B18 = 29'h0004_0000;
   localparam logic [28:0] ID_B = 29'h0aa4_0000;
   localparam logic [28:0] ID_X = 29'h0123_4567;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [5:0] i_addr = '0;
   logic [31:0] i_wr_data = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rd_data;
   logic i_frm_valid, i_frm_ext, i_frm_rtr, o_receive_done_irq, o_store_valid;
   logic [28:0] i_frm_id;
   logic [3:0] i_frm_dlc;
   logic [63:0] i_frm_data;
   logic [1:0] o_store_idx;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   cmb_rx_store #(.BUF_NUM(4), .HIST_DEPTH(5)) cmb_rx_store_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .i_frm_valid(i_frm_valid), .i_frm_id(i_frm_id), .i_frm_ext(i_frm_ext), .i_frm_rtr(i_frm_rtr),
      .i_frm_dlc(i_frm_dlc), .i_frm_data(i_frm_data), .o_receive_done_irq(o_receive_done_irq),
      .o_store_valid(o_store_valid), .o_store_idx(o_store_idx));
   cmb_frame_src cmb_frame_src_inst (.i_ref_clk(i_ref_clk), .o_frm_valid(i_frm_valid), .o_frm_id(i_frm_id),
      .o_frm_ext(i_frm_ext), .o_frm_rtr(i_frm_rtr), .o_frm_dlc(i_frm_dlc), .o_frm_data(i_frm_data));
   initial begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   function automatic logic [5:0] ba(input logic [1:0] b, input logic [2:0] s);
      return {1'b0, b, s};
   endfunction : ba
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk(nm, e, o_rd_data);
   endtask : rd
   task automatic setb(input logic [1:0] b, input logic [28:0] id, input logic [31:0] cfg, input logic [31:0] ctl);
      wr(ba(b, 3'h0), 32'(id));
      wr(ba(b, 3'h1), cfg);
      wr(ba(b, 3'h2), ctl);
   endtask : setb
   task automatic st(input logic v, input logic [1:0] ix, input logic irq);
      #1 chk("store_valid", 32'(v), 32'(o_store_valid));
      if (v) chk("store_idx", 32'(ix), 32'(o_store_idx));
      chk("irq", 32'(irq), 32'(o_receive_done_irq));
   endtask : st
   task automatic rst;
      @(posedge i_ref_clk);
      i_rst_b <= 1'b0;
      @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
   endtask : rst
   task automatic t_block;
      rst();
      wr(6'h20, 32'(B18));
      wr(6'h24, 32'h1);
      setb(2'h0, ID_A, 32'h0a, 32'h0);
      setb(2'h1, ID_A, 32'h0a, 32'h1);
      setb(2'h2, ID_A | B18, 32'h0b, 32'h1);
      setb(2'h3, ID_A | B18, 32'h0a, 32'h9);
      cmb_frame_src_inst.send(ID_A | B18, 1'b0, 4'h8, 64'h1111_2222_3333_4444, 1'b0);
      cmb_frame_src_inst.send(ID_A | B18, 1'b0, 4'h8, 64'h5555_6666_7777_8888, 1'b1);
      st(1'b1, 2'h3, 1'b1);
      cmb_frame_src_inst.send(ID_A | B18, 1'b0, 4'h1, 64'h9, 1'b1);
      st(1'b0, 2'h0, 1'b0);
      cmb_frame_src_inst.send(ID_A | 29'h0008_0000, 1'b0, 4'h1, 64'h9, 1'b1);
      st(1'b0, 2'h0, 1'b0);
      rd("data_lo", ba(2'h1, 3'h4), 32'h3333_4444);
      wr(ba(2'h1, 3'h1), 32'h1a);
      cmb_frame_src_inst.send(ID_A, 1'b0, 4'h2, 64'ha, 1'b1);
      st(1'b1, 2'h1, 1'b0);
      rd("hist", 6'h26, 32'h1);
      rd("hist", 6'h26, 32'h3);
      rd("hist", 6'h26, 32'h1);
   endtask : t_block
   task automatic t_remote;
      rst();
      wr(6'h24, 32'h1);
      setb(2'h0, ID_B, 32'h08, 32'h3);
      setb(2'h1, ID_B, 32'h08, 32'hd);
      setb(2'h2, ID_B, 32'h08, 32'h9);
      wr(ba(2'h1, 3'h4), 32'hcafe_0123);
      wr(ba(2'h1, 3'h3), 32'h2);
      cmb_frame_src_inst.send(ID_B, 1'b1, 4'h5, 64'hffff_ffff_ffff_ffff, 1'b1);
      st(1'b1, 2'h1, 1'b1);
      rd("length", ba(2'h1, 3'h3), 32'h5);
      rd("data_lo", ba(2'h1, 3'h4), 32'hcafe_0123);
      rd("control", ba(2'h1, 3'h2), 32'hd);
      rd("status", 6'h25, 32'h1);
      rd("hist", 6'h26, 32'h1);
      wr(6'h24, 32'h0);
      wr(6'h25, 32'h1);
      wr(ba(2'h1, 3'h2), 32'h9);
      cmb_frame_src_inst.send(ID_B, 1'b1, 4'h3, 64'h0, 1'b1);
      st(1'b1, 2'h1, 1'b0);
      rd("control", ba(2'h1, 3'h2), 32'hd);
      rd("status", 6'h25, 32'h1);
   endtask : t_remote
   // extended frames, unmasked class and mask four
   task automatic t_ext;
      rst();
      wr(6'h23, 32'h0000_00ff);
      setb(2'h0, ID_X, 32'h4d, 32'h1);
      setb(2'h1, ID_X, 32'h49, 32'h1);
      setb(2'h2, ID_X, 32'h09, 32'h1);
      cmb_frame_src_inst.send(ID_X, 1'b0, 4'h1, 64'h1, 1'b1);
      st(1'b1, 2'h2, 1'b0);
      cmb_frame_src_inst.send(ID_X, 1'b0, 4'h2, 64'h2, 1'b1, 1'b1);
      st(1'b1, 2'h1, 1'b0);
      cmb_frame_src_inst.send(ID_X ^ 29'h0000_0001, 1'b0, 4'h3, 64'h3, 1'b1, 1'b1);
      st(1'b1, 2'h0, 1'b0);
      rd("data_lo", ba(2'h0, 3'h4), 32'h3);
   endtask : t_ext
   task automatic wrap_up;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (3) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      t_block();
      t_remote();
      t_ext();
      wrap_up();
   end
endmodule : tb_cmb_rx_store
bind cmb_rx_store cmb_rx_chk #(.BUF_NUM(BUF_NUM)) cmb_rx_chk_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_frm_valid(i_frm_valid), .i_frm_ext(i_frm_ext),
   .i_frm_rtr(i_frm_rtr), .o_receive_done_irq(o_receive_done_irq), .o_store_valid(o_store_valid),
   .o_store_idx(o_store_idx));
